// file: descrambler.sv
/*
  Serial descrambler with idle-based lock and hold timer.
  Assumes a scrambled idle stream from the far end during acquisition.
*/
`timescale 1ns/100ps
module descrambler
  import rx_pcs_pkg::*;
#(
  parameter int HOLD_CYC = HOLD_CYC_DEF
) (
  input  wire logic clk_sys_i,   // Bit clock
  input  wire logic rst_n_i,     // Async reset, active low
  dsc_if.dsc        sif          // Serial bit link
);

  logic [LFSR_W-1:0] lfsr_q, lfsr_d;
  logic              lock_q, lock_d;
  logic [6:0]        run_q, run_d;
  logic [HOLD_W-1:0] hold_q, hold_d;
  logic              n_bit;
  logic              ud;

  // Predicted sequence bit and recovered data
  assign n_bit      = lfsr_q[LFSR_TAP_A] ^ lfsr_q[LFSR_TAP_B];
  assign ud         = sif.sd_bit ^ n_bit;
  assign sif.ud_bit = ud;
  assign sif.locked = lock_q;

  // Next-state: self-load while hunting, free-run and watch idles once locked
  always_comb begin
    lfsr_d = {lfsr_q[LFSR_W-2:0], lock_q ? n_bit : ~sif.sd_bit};
    lock_d = lock_q;
    hold_d = hold_q;
    run_d  = ud ? ((run_q == 7'h7f) ? run_q : run_q + 7'h01) : 7'h00;
    if (!lock_q) begin
      if (ud && run_q == LOCK_BITS - 7'h01) begin
        lock_d = 1'b1;
        hold_d = HOLD_W'(HOLD_CYC);
        run_d  = 7'h00;
      end
    end else if (ud && run_q == HOLD_IDLE_BITS - 7'h01) begin
      hold_d = HOLD_W'(HOLD_CYC);
      run_d  = 7'h00;
    end else if (hold_q == '0) begin
      lock_d = 1'b0;
      lfsr_d = '0;
      run_d  = 7'h00;
    end else begin
      hold_d = hold_q - HOLD_W'(1);
    end
  end

  // State registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lfsr_q <= '0;
      lock_q <= 1'b0;
      run_q  <= 7'h00;
      hold_q <= '0;
    end else begin
      lfsr_q <= lfsr_d;
      lock_q <= lock_d;
      run_q  <= run_d;
      hold_q <= hold_d;
    end
  end

endmodule

// file: dsc_if.sv
/*
  Serial link between the line decoder and the descrambler.
  Assumes both ends run on the same clock; one bit moves per edge.
*/
`timescale 1ns/100ps
interface dsc_if;
  logic sd_bit;   // Scrambled NRZ bit
  logic ud_bit;   // Unscrambled bit
  logic locked;   // Descrambler in synchronisation

  modport line (output sd_bit, input ud_bit, input locked);
  modport dsc  (input sd_bit, output ud_bit, output locked);
endinterface

// file: fast_ethernet_rx_pcs.sv
/*
  Digital receive path of a 100 Mb/s twisted-pair PHY plus the transmit MLT-3 splitter.
  Assumes one line bit per clock, inputs synchronous to clk_sys_i, and an
  analog front end that supplies equalised levels and a raw energy detect.
*/
`timescale 1ns/100ps
module fast_ethernet_rx_pcs
  import rx_pcs_pkg::*;
#(
  parameter int HOLD_CYC = HOLD_CYC_DEF,   // Descrambler hold time in cycles
  parameter int LINK_CYC = LINK_CYC_DEF    // Signal detect qualification in cycles
) (
  input  wire logic        clk_sys_i,                  // Bit clock, 25 MHz
  input  wire logic        rst_n_i,                    // Async reset, active low
  input  wire logic [1:0]  rx_mlt3_i,                  // Equalised level: 0, +1, -1
  input  wire logic        sig_energy_i,               // Raw energy above threshold
  input  wire logic        link_pulse_i,               // Pulse activity seen by front end
  input  wire logic        dsc_bypass_i,               // Skip the descrambler
  input  wire logic        tx_nrzi_i,                  // Serial transmit NRZI bit
  output logic             tx_pos_o,                   // Driver leg, positive half
  output logic             tx_neg_o,                   // Driver leg, negative half
  output logic             sig_det_o,                  // Qualified signal detect
  output logic             link_up_o,                  // Link monitor state
  output logic             locked_o,                   // Descrambler synchronised
  output logic [3:0]       rxd_o,                      // Received nibble
  output logic             rx_stb_o,                   // One pulse per code-group period
  output logic             rx_dv_o,                    // Packet data valid
  output logic             rx_er_o,                    // Receive error
  output logic             crs_o,                      // Carrier sense
  output logic [15:0]      false_carrier_event_count_o // Bad start counter
);

  // Table lookup: {valid, nibble}; control and invalid groups return invalid
  function automatic logic [4:0] dec5(input logic [4:0] g);
    logic [4:0] r;
    r = 5'h00;
    case (g)
      5'h1e: r = 5'h10;
      5'h09: r = 5'h11;
      5'h14: r = 5'h12;
      5'h15: r = 5'h13;
      5'h0a: r = 5'h14;
      5'h0b: r = 5'h15;
      5'h0e: r = 5'h16;
      5'h0f: r = 5'h17;
      5'h12: r = 5'h18;
      5'h13: r = 5'h19;
      5'h16: r = 5'h1a;
      5'h17: r = 5'h1b;
      5'h1a: r = 5'h1c;
      5'h1b: r = 5'h1d;
      5'h1c: r = 5'h1e;
      5'h1d: r = 5'h1f;
      default: r = 5'h00;
    endcase
    return r;
  endfunction

  dsc_if sif ();

  descrambler #(
    .HOLD_CYC (HOLD_CYC)
  ) u_dsc (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .sif       (sif)
  );

  // Line decode and link monitor state
  logic [1:0]        mlt_q, mlt_d;
  logic              nrzi_q, nrzi_d;
  logic              nrz_q, nrz_d;
  logic              sd_q, sd_d;
  logic [LINK_W-1:0] lk_cnt_q, lk_cnt_d;
  logic              link_q, link_d;

  // Transmit splitter state
  logic              tx_prev_q, tx_prev_d;
  logic              tx_ph_q, tx_ph_d;
  logic              pos_q, pos_d;
  logic              neg_q, neg_d;

  // Alignment and decode state
  rx_state_t         st_q, st_d;
  logic [9:0]        sh_q, sh_d;
  logic [3:0]        ones_q, ones_d;
  logic [2:0]        cnt_q, cnt_d;
  logic [2:0]        ph_q, ph_d;
  logic [1:0]        idl_q, idl_d;
  logic              t_q, t_d;
  logic [3:0]        rxd_q, rxd_d;
  logic              stb_q, stb_d;
  logic              dv_q, dv_d;
  logic              er_q, er_d;
  logic              crs_q, crs_d;
  logic [15:0]       fcc_q, fcc_d;

  logic              abit;
  logic [4:0]        grp;
  logic [4:0]        look;

  // Serial NRZ goes to the descrambler; the aligner picks its source
  assign sif.sd_bit = nrz_q;
  assign abit       = dsc_bypass_i ? nrz_q : sif.ud_bit;

  // Line decode: level change makes NRZI toggle, NRZI toggle is an NRZ one
  always_comb begin
    mlt_d  = rx_mlt3_i;
    nrzi_d = nrzi_q ^ (rx_mlt3_i != mlt_q);
    nrz_d  = nrzi_d ^ nrzi_q;
    // Pulse activity masks energy so autonegotiation bursts never qualify
    sd_d   = sig_energy_i & ~link_pulse_i;
    lk_cnt_d = lk_cnt_q;
    link_d   = link_q;
    if (!sd_q) begin
      lk_cnt_d = '0;
      link_d   = 1'b0;
    end else if (lk_cnt_q == LINK_W'(LINK_CYC - 1)) begin
      link_d   = 1'b1;
    end else begin
      lk_cnt_d = lk_cnt_q + LINK_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mlt_q    <= MLT_ZERO;
      nrzi_q   <= 1'b0;
      nrz_q    <= 1'b0;
      sd_q     <= 1'b0;
      lk_cnt_q <= '0;
      link_q   <= 1'b0;
    end else begin
      mlt_q    <= mlt_d;
      nrzi_q   <= nrzi_d;
      nrz_q    <= nrz_d;
      sd_q     <= sd_d;
      lk_cnt_q <= lk_cnt_d;
      link_q   <= link_d;
    end
  end

  // Transmit splitter: each rising NRZI edge swaps legs, so ones alternate.
  // There is deliberately no path that drives plain binary onto the pair.
  always_comb begin
    tx_prev_d = tx_nrzi_i;
    tx_ph_d   = tx_ph_q ^ (tx_nrzi_i & ~tx_prev_q);
    pos_d     = link_q & tx_nrzi_i & tx_ph_d;
    neg_d     = link_q & tx_nrzi_i & ~tx_ph_d;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_prev_q <= 1'b0;
      tx_ph_q   <= 1'b0;
      pos_q     <= 1'b0;
      neg_q     <= 1'b0;
    end else begin
      tx_prev_q <= tx_prev_d;
      tx_ph_q   <= tx_ph_d;
      pos_q     <= pos_d;
      neg_q     <= neg_d;
    end
  end

  // Code-group view of the newest five bits
  always_comb begin
    sh_d = {sh_q[8:0], abit};
    grp  = sh_d[4:0];
    look = dec5(grp);
  end

  // Alignment, delimiter handling and nibble output
  always_comb begin
    st_d   = st_q;
    ones_d = abit ? ((ones_q == IDLE_RUN) ? ones_q : ones_q + 4'h1) : 4'h0;
    cnt_d  = cnt_q + 3'h1;
    ph_d   = (ph_q == PH_LAST) ? 3'h0 : ph_q + 3'h1;
    idl_d  = idl_q;
    t_d    = t_q;
    rxd_d  = rxd_q;
    stb_d  = 1'b0;
    dv_d   = dv_q;
    er_d   = er_q;
    crs_d  = crs_q;
    fcc_d  = fcc_q;
    case (st_q)
      ST_IDLE: begin
        dv_d  = 1'b0;
        er_d  = 1'b0;
        crs_d = 1'b0;
        // The first zero after a run of idle ones opens a start check
        if (!abit && ones_q == IDLE_RUN && (sif.locked || dsc_bypass_i)) begin
          st_d  = ST_SSD_CHK;
          cnt_d = 3'h0;
          crs_d = 1'b1;
        end
      end
      ST_SSD_CHK: begin
        if (cnt_q == J_END_CNT) begin
          if (grp == CG_J) begin
            rxd_d = NIB_PREAMBLE;
            stb_d = 1'b1;
            dv_d  = 1'b1;
          end else begin
            st_d  = ST_BAD;
            fcc_d = fcc_q + 16'h0001;
            ph_d  = 3'h0;
            idl_d = 2'h0;
          end
        end else if (cnt_q == K_END_CNT) begin
          if (sh_d == {CG_J, CG_K}) begin
            st_d  = ST_PKT;
            rxd_d = NIB_PREAMBLE;
            stb_d = 1'b1;
            ph_d  = 3'h0;                                             // Boundary now fixed
            idl_d = 2'h0;
            t_d   = 1'b0;
          end else begin
            st_d  = ST_BAD;
            fcc_d = fcc_q + 16'h0001;
            ph_d  = 3'h0;
            idl_d = 2'h0;
          end
        end
      end
      ST_PKT: begin
        if (ph_q == PH_LAST) begin
          stb_d = 1'b1;
          er_d  = 1'b0;
          t_d   = 1'b0;
          idl_d = (grp == CG_IDLE) ? idl_q + 2'h1 : 2'h0;
          if (t_q && grp == CG_R) begin
            st_d  = ST_IDLE;
            stb_d = 1'b0;
            dv_d  = 1'b0;
            crs_d = 1'b0;
          end else if (grp == CG_IDLE && idl_q == MIN_IDLES - 2'h1) begin
            st_d  = ST_IDLE;
            stb_d = 1'b0;
            dv_d  = 1'b0;
            crs_d = 1'b0;
          end else if (grp == CG_T && !t_q) begin
            t_d   = 1'b1;                                             // Held for the next group only, which must be R
            stb_d = 1'b0;
          end else begin
            // A lone T, or any control or unused group, is a data error
            rxd_d = look[3:0];
            er_d  = t_q | ~look[4];
          end
        end
      end
      ST_BAD: begin
        crs_d = 1'b1;
        dv_d  = 1'b0;
        er_d  = 1'b1;
        if (ph_q == PH_LAST) begin
          stb_d = 1'b1;
          rxd_d = NIB_BAD_SSD;
          idl_d = (grp == CG_IDLE) ? idl_q + 2'h1 : 2'h0;
          if (grp == CG_IDLE && idl_q == MIN_IDLES - 2'h1) begin
            st_d  = ST_IDLE;
            stb_d = 1'b0;
            er_d  = 1'b0;
            crs_d = 1'b0;
            rxd_d = NIB_ZERO;
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    // Without link, or if lock is lost while the descrambler is not bypassed, the receive PCS sits quiet
    if (!link_q || (!sif.locked && !dsc_bypass_i)) begin
      st_d  = ST_IDLE;
      stb_d = 1'b0;
      dv_d  = 1'b0;
      er_d  = 1'b0;
      crs_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q   <= ST_IDLE;
      sh_q   <= '0;
      ones_q <= 4'h0;
      cnt_q  <= 3'h0;
      ph_q   <= 3'h0;
      idl_q  <= 2'h0;
      t_q    <= 1'b0;
      rxd_q  <= NIB_ZERO;
      stb_q  <= 1'b0;
      dv_q   <= 1'b0;
      er_q   <= 1'b0;
      crs_q  <= 1'b0;
      fcc_q  <= 16'h0000;
    end else begin
      st_q   <= st_d;
      sh_q   <= sh_d;
      ones_q <= ones_d;
      cnt_q  <= cnt_d;
      ph_q   <= ph_d;
      idl_q  <= idl_d;
      t_q    <= t_d;
      rxd_q  <= rxd_d;
      stb_q  <= stb_d;
      dv_q   <= dv_d;
      er_q   <= er_d;
      crs_q  <= crs_d;
      fcc_q  <= fcc_d;
    end
  end

  // All outputs come straight from flip-flops
  assign tx_pos_o  = pos_q;
  assign tx_neg_o  = neg_q;
  assign sig_det_o = sd_q;
  assign link_up_o = link_q;
  assign locked_o  = sif.locked;
  assign rxd_o     = rxd_q;
  assign rx_stb_o  = stb_q;
  assign rx_dv_o   = dv_q;
  assign rx_er_o   = er_q;
  assign crs_o     = crs_q;
  assign false_carrier_event_count_o = fcc_q;

endmodule

// file: line_src.sv
/*
  Remote line transmitter model: scrambles, NRZI-codes and MLT-3 levels one bit per clock.
  Assumes the bench hands it one NRZ bit per rising edge of the shared clock.
*/
`timescale 1ns/100ps
module line_src
  import rx_pcs_pkg::*;
(
  input  wire logic       clk_sys_i, // Bit clock
  input  wire logic       rst_n_i,   // Async reset, active low
  input  wire logic       bit_i,     // Unscrambled NRZ bit
  input  wire logic       scr_en_i,  // Scramble before coding
  output logic      [1:0] mlt_o      // Equalised line level
);
  logic [10:0] lfsr_q, lfsr_d;
  logic [1:0]  ph_q, ph_d;
  logic        sd;

  // Side-stream scrambler, its LFSR free-running apart from the data; each one steps the MLT-3 walk 0,+,0,-
  always_comb begin
    lfsr_d = {lfsr_q[9:0], lfsr_q[LFSR_TAP_A] ^ lfsr_q[LFSR_TAP_B]};
    sd     = bit_i ^ (scr_en_i & lfsr_d[0]);
    ph_d   = ph_q + {1'b0, sd};
  end

  // Seed only has to be nonzero, or the sequence would stay all zeros
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lfsr_q <= 11'h5a3;
      ph_q   <= 2'h0;
    end else begin
      lfsr_q <= lfsr_d;
      ph_q   <= ph_d;
    end
  end

  // Level from phase: even phases sit at zero
  assign mlt_o = ph_q[0] ? (ph_q[1] ? MLT_NEG : MLT_POS) : MLT_ZERO;
endmodule

// file: rx_pcs_pkg.sv
/*
  Constants shared by the 100 Mb/s receive path: timing, code-groups, line levels.
  Assumes a single 25 MHz clock that carries one line bit per edge.
*/
package rx_pcs_pkg;

  // Clock and derived timer counts
  localparam int CLK_PERIOD_NS = 40;
  localparam int HOLD_TIME_US  = 722;
  localparam int HOLD_CYC_DEF  = (HOLD_TIME_US * 1000) / CLK_PERIOD_NS;  // Longest: round down
  localparam int LINK_TIME_US  = 395;
  localparam int LINK_CYC_DEF  = (LINK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W        = 15;
  localparam int LINK_W        = 14;

  // Descrambler
  localparam int       LFSR_W          = 11;
  localparam int       LFSR_TAP_A      = 10;     // x^11
  localparam int       LFSR_TAP_B      = 8;      // x^9
  localparam int       GROUP_BITS      = 5;
  localparam int       LOCK_IDLE_GRPS  = 12;
  localparam logic [6:0] LOCK_BITS     = 7'(LOCK_IDLE_GRPS * GROUP_BITS);
  localparam logic [6:0] HOLD_IDLE_BITS = 7'h3a;  // 58 bit times

  // Line levels of the equalised three-level symbol
  localparam logic [1:0] MLT_ZERO = 2'h0;
  localparam logic [1:0] MLT_POS  = 2'h1;
  localparam logic [1:0] MLT_NEG  = 2'h3;

  // Code-groups
  localparam logic [4:0] CG_IDLE = 5'h1f;
  localparam logic [4:0] CG_J    = 5'h18;
  localparam logic [4:0] CG_K    = 5'h11;
  localparam logic [4:0] CG_T    = 5'h0d;
  localparam logic [4:0] CG_R    = 5'h07;

  // Nibbles and counts used by the decoder
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;
  localparam logic [3:0] NIB_BAD_SSD  = 4'he;
  localparam logic [3:0] NIB_ZERO     = 4'h0;
  localparam logic [3:0] IDLE_RUN     = 4'ha;   // Ones needed before a start counts as framed
  localparam logic [1:0] MIN_IDLES    = 2'h2;
  localparam logic [2:0] J_END_CNT    = 3'h1;   // Bits after the first J zero until J ends
  localparam logic [2:0] K_END_CNT    = 3'h6;   // Bits after the first J zero until K ends
  localparam logic [2:0] PH_LAST      = 3'h4;

  typedef enum logic [1:0] {ST_IDLE, ST_SSD_CHK, ST_PKT, ST_BAD} rx_state_t;

endpackage

// file: rx_pcs_sva.sv
/*
  Port checker for the receive path and transmit splitter, bound onto the top module.
  Assumes all outputs clear in reset and one line bit per clock.
*/
`timescale 1ns/100ps
module rx_pcs_sva
  import rx_pcs_pkg::*;
#(
  parameter int HOLD_CYC = HOLD_CYC_DEF,
  parameter int LINK_CYC = LINK_CYC_DEF
) (
  input wire logic        clk_sys_i,                  // Bit clock
  input wire logic        rst_n_i,                    // Async reset, active low
  input wire logic        link_pulse_i,               // Pulse activity
  input wire logic        tx_nrzi_i,                  // Transmit bit
  input wire logic        tx_pos_o,                   // Positive leg
  input wire logic        tx_neg_o,                   // Negative leg
  input wire logic        sig_det_o,                  // Signal detect
  input wire logic        link_up_o,                  // Link state
  input wire logic [3:0]  rxd_o,                      // Nibble
  input wire logic        rx_stb_o,                   // Group strobe
  input wire logic        rx_dv_o,                    // Data valid
  input wire logic        rx_er_o,                    // Error
  input wire logic        crs_o,                      // Carrier
  input wire logic [15:0] false_carrier_event_count_o // Bad start count
);
  int         run_q, run_d;
  logic [1:0] leg_q, leg_d;

  // Detect run length, and which leg fired last (cleared while link is down)
  always_comb begin
    run_d = sig_det_o ? run_q + 1 : 0;
    leg_d = !link_up_o ? 2'h0 : (tx_pos_o ? 2'h1 : (tx_neg_o ? 2'h2 : leg_q));
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= 0;
      leg_q <= 2'h0;
    end else begin
      run_q <= run_d;
      leg_q <= leg_d;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_pulse_mask; link_pulse_i |=> !sig_det_o; endproperty
  property p_link_qual; $rose(link_up_o) |-> run_q >= LINK_CYC - 1; endproperty
  property p_link_drop; !sig_det_o |=> !link_up_o; endproperty
  property p_tx_down; !link_up_o |=> !tx_pos_o && !tx_neg_o; endproperty
  property p_tx_event; $rose(tx_nrzi_i) && link_up_o |=> tx_pos_o != tx_neg_o; endproperty
  property p_tx_alt; $rose(tx_pos_o) |-> leg_q != 2'h1; endproperty
  property p_fc_step;
    $changed(false_carrier_event_count_o) |->
      false_carrier_event_count_o == $past(false_carrier_event_count_o) + 16'h1;
  endproperty
  property p_fc_err; $changed(false_carrier_event_count_o) |-> ##[0:1] (rx_er_o && crs_o);
  endproperty
  property p_bad_nib; rx_stb_o && rx_er_o && !rx_dv_o |-> rxd_o == NIB_BAD_SSD; endproperty
  property p_bad_end; $fell(crs_o) && !rx_dv_o |-> !rx_er_o; endproperty
  property p_pre; $rose(rx_dv_o) |-> rx_stb_o && rxd_o == NIB_PREAMBLE; endproperty
  property p_stb_gap; rx_stb_o |=> !rx_stb_o [*4]; endproperty
  property p_gate; !link_up_o |=> !rx_stb_o && !crs_o; endproperty

  a_pulse_mask: assert property (p_pulse_mask) else $error("detect during pulses");
  a_link_qual: assert property (p_link_qual) else $error("link up too early");
  a_link_drop: assert property (p_link_drop) else $error("link held without detect");
  a_tx_down: assert property (p_tx_down) else $error("legs driven, link down");
  a_tx_event: assert property (p_tx_event) else $error("no single leg on a one");
  a_tx_alt: assert property (p_tx_alt) else $error("positive leg fired twice");
  a_fc_step: assert property (p_fc_step) else $error("counter step not one");
  a_fc_err: assert property (p_fc_err) else $error("bad start without error");
  a_bad_nib: assert property (p_bad_nib) else $error("bad start nibble wrong");
  a_bad_end: assert property (p_bad_end) else $error("error outlives carrier");
  a_pre: assert property (p_pre) else $error("packet without preamble");
  a_stb_gap: assert property (p_stb_gap) else $error("strobes closer than a group");
  a_gate: assert property (p_gate) else $error("decoding with link down");

  c_pkt: cover property ($rose(rx_dv_o));
  c_bad: cover property ($changed(false_carrier_event_count_o));
  c_link: cover property ($fell(link_up_o));
endmodule

bind fast_ethernet_rx_pcs rx_pcs_sva #(.HOLD_CYC(HOLD_CYC), .LINK_CYC(LINK_CYC)) i_sva (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link_pulse_i(link_pulse_i),
  .tx_nrzi_i(tx_nrzi_i), .tx_pos_o(tx_pos_o), .tx_neg_o(tx_neg_o), .sig_det_o(sig_det_o),
  .link_up_o(link_up_o), .rxd_o(rxd_o), .rx_stb_o(rx_stb_o), .rx_dv_o(rx_dv_o),
  .rx_er_o(rx_er_o), .crs_o(crs_o),
  .false_carrier_event_count_o(false_carrier_event_count_o));

// file: tb.sv
/*
  Self-checking bench: remote line model feeds code-groups, strobed nibbles are compared.
  Assumes shortened hold and link counts; everything runs on one 25 MHz clock.
*/
`timescale 1ns/100ps
module tb;
  import rx_pcs_pkg::*;
  localparam int HC = 200;
  localparam int LC = 20;
  localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  localparam logic [4:0] CTL [5] = '{CG_J, CG_K, CG_R, 5'h04, CG_IDLE};
  logic        clk_sys_i, rst_n_i, energy, pulse, bypass, nrzi, lbit, scr;
  logic        tx_pos, tx_neg, sig_det, link_up, locked, stb, dv, er, crs;
  logic [1:0]  mlt;
  logic [3:0]  rxd;
  logic [15:0] fc_cnt;
  logic [5:0]  got_q[$], exp_q[$];
  int          error_cnt, n_compared, seed, cyc, n, pos_n, neg_n;

  line_src i_src (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bit_i(lbit), .scr_en_i(scr),
                  .mlt_o(mlt));

  fast_ethernet_rx_pcs #(.HOLD_CYC(HC), .LINK_CYC(LC)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rx_mlt3_i(mlt), .sig_energy_i(energy),
    .link_pulse_i(pulse), .dsc_bypass_i(bypass), .tx_nrzi_i(nrzi), .tx_pos_o(tx_pos),
    .tx_neg_o(tx_neg), .sig_det_o(sig_det), .link_up_o(link_up), .locked_o(locked),
    .rxd_o(rxd), .rx_stb_o(stb), .rx_dv_o(dv), .rx_er_o(er), .crs_o(crs),
    .false_carrier_event_count_o(fc_cnt));

  // Clock, 40 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // Collect strobed groups, drive random transmit bits, cut a hang short
  always @(posedge clk_sys_i) begin
    cyc++;
    if (stb) got_q.push_back({er, dv, rxd});
    pos_n += int'(tx_pos);
    neg_n += int'(tx_neg);
    if (rst_n_i) nrzi <= 1'($random(seed));
    if (cyc == 10000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // Expected {error, valid, nibble} for a group inside a packet; control groups are errors
  function automatic logic [5:0] exp_grp(input logic [4:0] cg);
    logic [5:0] r;
    r = {2'b11, NIB_ZERO};
    for (int i = 0; i < 16; i++) begin
      if (ENC[i] == cg) r = {2'b01, 4'(i)};
    end
    return r;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Whole code-group, first bit on the line is bit 4
  task automatic send(input logic [4:0] cg);
    for (int i = 4; i >= 0; i--) begin
      lbit <= cg[i];
      @(posedge clk_sys_i);
    end
  endtask

  task automatic idles(input int g);
    repeat (g) send(CG_IDLE);
  endtask

  // Expected entry is {error, valid, nibble}; preamble stands for J and for K
  task automatic pkt(input int len, input logic [4:0] bad);
    logic [3:0] nib;
    got_q = {};
    exp_q = {6'h15, 6'h15};
    idles(4);
    send(CG_J);
    send(CG_K);
    for (int k = 0; k < len; k++) begin
      nib = (len == 16) ? 4'(k) : 4'($random(seed));
      send(ENC[nib]);
      exp_q.push_back(exp_grp(ENC[nib]));
    end
    if (bad != 5'h00) begin
      send(bad);
      exp_q.push_back(exp_grp(bad));
    end
    if (bad != CG_IDLE) begin
      send(CG_T);
      send(CG_R);
    end
    idles(4);
    chk(16'(got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[k]) if (k < got_q.size()) chk(16'(got_q[k]), 16'(exp_q[k]));
    chk(16'({dv, crs, er}), 16'h0);
    $display("packet of %0d groups done", len);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence: lock on scrambled idles, then bypassed decoding, then link checks
  initial begin
    {pulse, nrzi, bypass, rst_n_i} = 4'h0;
    {energy, scr, lbit} = 3'h7;
    {error_cnt, n_compared, cyc, n, pos_n, neg_n} = '0;
    seed = 62409;
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    while (!link_up && n < 400) begin @(posedge clk_sys_i); n++; end
    chk(16'(n >= LC + 1 && n <= LC + 3), 16'h1);
    while (!locked && n < 400) begin @(posedge clk_sys_i); n++; end
    chk(16'(n >= 60 && n < 400), 16'h1);
    n = 0;
    repeat (100) begin send(CG_IDLE); n += int'(!locked); end
    chk(16'(n), 16'h0);
    pkt(6, 5'h00);
    // One more idle run reloads the hold timer at a known point, so the countdown below
    // is measured from there and not from some reload before the packet
    idles(12);
    n = 0;
    while (locked && n < 400) begin send(ENC[0]); n += 5; end
    chk(16'(n >= HC - 65 && n <= HC + 30), 16'h1);
    $display("lock and hold done");
    scr <= 1'b0;
    bypass <= 1'b1;
    idles(10);
    pkt(16, 5'h00);
    repeat (5) pkt(1 + ($random(seed) & 7), 5'h00);
    foreach (CTL[c]) pkt(2, CTL[c]);
    for (int r = 0; r < 3; r++) begin
      n = int'(fc_cnt);
      got_q = {};
      idles(4);
      send(5'h14);
      send(ENC[4'($random(seed))]);
      send(5'h0a);
      idles(4);
      chk(fc_cnt, 16'(n + 1));
      chk(16'({crs, er}), 16'h0);
      chk(16'(got_q.size() >= 2), 16'h1);
      foreach (got_q[k]) chk(16'(got_q[k]), 16'h2e);
    end
    $display("bad start done");
    chk(16'(pos_n > 0 && neg_n > 0), 16'h1);
    energy <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk(16'(link_up), 16'h0);
    pulse <= 1'b1;
    energy <= 1'b1;
    repeat (LC + 10) @(posedge clk_sys_i);
    chk(16'({sig_det, link_up}), 16'h0);
    pulse <= 1'b0;
    repeat (LC + 4) @(posedge clk_sys_i);
    chk(16'(link_up), 16'h1);
    $display("link monitor done");
    tally_and_finish();
  end
endmodule
